// File: design/lfssw_defines.svh
`ifndef LFSSW_DEFINES_SVH
`define LFSSW_DEFINES_SVH

// ==========================================================
// timing
`define LFSSW_CLK_PERIOD_NS      10
`define LFSSW_DOM_TIMEOUT_US     100
`define LFSSW_DOM_CNT_W          20

// ==========================================================
// spi frame layout
`define LFSSW_FRAME_BITS         5'h10
`define LFSSW_FIXED_BITS         5'h08
`define LFSSW_CMD_WRITE          2'h1
`define LFSSW_CMD_RD_FLAGS_CH0   16'h2780
`define LFSSW_CMD_RD_FLAGS_CH1   16'h2980
`define LFSSW_STATUS_RESET       16'h0000

// ==========================================================
// status word bit positions
`define LFSSW_ST_INT             15
`define LFSSW_ST_WAKE            14
`define LFSSW_ST_RST             13
`define LFSSW_ST_CAN_G           12
`define LFSSW_ST_LIN_G           11
`define LFSSW_ST_IO_G            10
`define LFSSW_ST_SAFE_G          9
`define LFSSW_ST_REG_G           8
`define LFSSW_ST_CAN_BUS         7
`define LFSSW_ST_CAN_LOCAL       6
`define LFSSW_ST_SER2            5
`define LFSSW_ST_SER1            4
`define LFSSW_ST_IO_HI           3
`define LFSSW_ST_IO_LO           2
`define LFSSW_ST_REG_HI          1
`define LFSSW_ST_REG_LO          0

// ==========================================================
// latched fault flag positions
`define LFSSW_NUM_CH             2
`define LFSSW_NUM_FAULTS         6
`define LFSSW_F_DOM              0
`define LFSSW_F_TERM             1
`define LFSSW_F_OVT              2
`define LFSSW_F_RXL              3
`define LFSSW_F_RXH              4
`define LFSSW_F_TXL              5

`endif

// File: design/lfssw_pkg.sv
package lfssw_pkg;

    // ==========================================================
    // detector and mode inputs of one serial bus channel
    typedef struct packed {
        logic bus_dominant;   // bus seen dominant now
        logic term_short;     // termination short to ground
        logic overtemp;       // thermal sensor above threshold
        logic rxd_low;        // receive output shorted to ground
        logic rxd_high;       // receive output stuck recessive
        logic txd_low;        // transmit input shorted to ground
        logic wake_det;       // wake detector level
        logic trx_mode;       // channel in transmit/receive mode
        logic wake_rx_en;     // sleep with wake-up enabled
    } lfssw_lin_in_t;

    // ==========================================================
    // flag view of one channel
    typedef struct packed {
        logic dom_clamp;
        logic trx_state;
        logic wake_rx;
        logic wake_src;
        logic term_short;
        logic overtemp;
        logic rxd_low;
        logic rxd_high;
        logic txd_low;
    } lfssw_lin_flags_t;

    // ==========================================================
    // pending summaries from the other flag groups
    typedef struct packed {
        logic int_pend;
        logic wake_pend;
        logic rst_pend;
        logic can_bus;
        logic can_local;
        logic io_hi;
        logic io_lo;
        logic safe;
        logic reg_hi;
        logic reg_lo;
    } lfssw_ext_src_t;

endpackage

// File: design/lfssw_status.sv
`timescale 1ns/10ps
`include "lfssw_defines.svh"
// Behaviour
// RL1: dominant bus beyond timeout latches clamp flag
// RL2: transceiver-state bit is live, reads keep it
// RL3: state bit falls when leaving transmit/receive
// RL4: wake-receiver bit mirrors wake enable, real time
// RL5: wake-source flag latches, clears on read
// RL6: termination short flag clears after recovery, read
// RL7: overtemperature flag clears when cool and read
// RL8: receive-low flag clears after recovery and read
// RL9: receive-recessive flag clears after recovery, read
// RL10: transmit-low flag clears after recovery and read
// RL11: every frame shifts fixed status on MISO
// RL12: write command returns fixed then extended byte
// RL13: read command returns fixed byte only
// RL14: bit 15 summarises pending interrupt flags
// RL15: bit 14 summarises pending wake flags
// RL16: bit 13 summarises pending reset flags
// RL17: bits 12-8 name the source group
// RL18: CAN bus/local bits also set CAN group
// RL19: bit 5 second channel, bit 4 first
// RL20: bits 3/2 name high/low I/O sub-address
// RL21: bits 1/0 name high/low regulator sub-address
// RL22: summary bits derive from flags, clear with them
module lfssw_status #(
    parameter int DOM_CYCLES =
        (`LFSSW_DOM_TIMEOUT_US * 1000 + `LFSSW_CLK_PERIOD_NS - 1) / `LFSSW_CLK_PERIOD_NS
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire lfssw_pkg::lfssw_lin_in_t [1:0]         lin_in,
    input  wire lfssw_pkg::lfssw_ext_src_t              ext_src,
    output      lfssw_pkg::lfssw_lin_flags_t [1:0]      lin_flags,
    output      logic [15:0]                            status_word,
    input  wire logic                                   spi_sclk,
    input  wire logic                                   spi_cs_n,
    input  wire logic                                   spi_mosi,
    output      logic                                   spi_miso_out,
    output      logic                                   spi_miso_oe_n
);
    import lfssw_pkg::*;

    // ==========================================================
    // reset release
    logic       rst_ff1;         // first reset stage
    logic       rst_sync_n;      // reset used by the clk domain

    // reset asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff1    <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_ff1    <= 1'b1;
            rst_sync_n <= rst_ff1;
        end
    end

    // ==========================================================
    // pin synchronisers
    lfssw_lin_in_t [1:0] pin_ff1;    // first stage, read only by stage two
    lfssw_lin_in_t [1:0] pin_s;      // synchronised detector levels
    logic                cs_ff1;     // chip select first stage
    logic                cs_s;       // chip select, high when idle

    // two flops on every asynchronous detector and the select
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_ff1 <= '0;
            pin_s   <= '0;
            cs_ff1  <= 1'b1;
            cs_s    <= 1'b1;
        end else begin
            pin_ff1 <= lin_in;
            pin_s   <= pin_ff1;
            cs_ff1  <= spi_cs_n;
            cs_s    <= cs_ff1;
        end
    end

    // ==========================================================
    // link side: frame counter and command capture
    logic [4:0]  bit_cnt;        // bits taken in this frame
    logic [14:0] rx_shift;       // command bits, msb first
    logic [1:0]  cmd_type;       // command_type_bits of the frame
    logic        rd_tgl;         // toggles on each flag-read frame
    logic        rd_ch;          // channel of the last flag read
    logic [15:0] status_hold;    // word frozen during a frame
    logic [15:0] full_cmd;       // complete command on the last edge

    assign full_cmd = {rx_shift, spi_mosi};

    // counter and shifter end with the frame's own select
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt  <= 5'h00;
            rx_shift <= 15'h0000;
            cmd_type <= 2'h0;
        end else begin
            // count saturates after a whole frame
            if (bit_cnt != `LFSSW_FRAME_BITS) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            rx_shift <= {rx_shift[13:0], spi_mosi};
            // type known after the second bit
            if (bit_cnt == 5'h01) begin
                cmd_type <= {rx_shift[0], spi_mosi};
            end
        end
    end

    // flag-read commands become a toggle for the clk domain
    always_ff @(posedge spi_sclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_tgl <= 1'b0;
            rd_ch  <= 1'b0;
        end else if (!spi_cs_n && bit_cnt == `LFSSW_FRAME_BITS - 5'h01) begin
            if (full_cmd == `LFSSW_CMD_RD_FLAGS_CH0) begin
                rd_tgl <= ~rd_tgl;
                rd_ch  <= 1'b0;
            end else if (full_cmd == `LFSSW_CMD_RD_FLAGS_CH1) begin
                rd_tgl <= ~rd_tgl;
                rd_ch  <= 1'b1;
            end
        end
    end

    // status bits shift out msb first, second byte only on writes
    always_comb begin
        spi_miso_out = 1'b0;
        if (bit_cnt < `LFSSW_FIXED_BITS) begin
            spi_miso_out = status_hold[4'hF - bit_cnt[3:0]];                // RL11
        end else if (bit_cnt < `LFSSW_FRAME_BITS
                     && cmd_type == `LFSSW_CMD_WRITE) begin
            spi_miso_out = status_hold[4'hF - bit_cnt[3:0]];                // RL12
        end
    end
    // reads leave the second byte at zero: RL13 lies in the branch above

    // miso drives only inside a frame
    assign spi_miso_oe_n = spi_cs_n;

    // ==========================================================
    // read event crossing
    logic       tgl_ff1;         // first stage of the toggle
    logic       tgl_s;           // synchronised toggle
    logic       tgl_d;           // previous synchronised toggle
    logic [1:0] rd_pulse;        // one-cycle flag read per channel

    // toggle passes two flops, a third finds its edge
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tgl_ff1 <= 1'b0;
            tgl_s   <= 1'b0;
            tgl_d   <= 1'b0;
        end else begin
            tgl_ff1 <= rd_tgl;
            tgl_s   <= tgl_ff1;
            tgl_d   <= tgl_s;
        end
    end

    // channel is settled long before the toggle edge arrives
    assign rd_pulse[0] = (tgl_s ^ tgl_d) & ~rd_ch;
    assign rd_pulse[1] = (tgl_s ^ tgl_d) & rd_ch;

    // ==========================================================
    // per-channel flags
    logic [`LFSSW_DOM_CNT_W-1:0]    dom_cnt  [2];    // dominant duration
    logic [`LFSSW_NUM_FAULTS-1:0]   fault_s  [2];    // live fault levels
    logic [`LFSSW_NUM_FAULTS-1:0]   latched  [2];    // latched fault flags
    logic [1:0]                     wake_d;          // previous wake level
    logic [1:0]                     wake_evt;        // wake rising edge
    logic [1:0]                     wake_flag;       // wake source flag

    for (genvar c = 0; c < `LFSSW_NUM_CH; c++) begin : g_ch
        // dominant timer, saturating at the timeout
        always_ff @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                dom_cnt[c] <= '0;
            end else if (!pin_s[c].bus_dominant) begin
                dom_cnt[c] <= '0;
            end else if (dom_cnt[c] != `LFSSW_DOM_CNT_W'(DOM_CYCLES)) begin
                dom_cnt[c] <= dom_cnt[c] + `LFSSW_DOM_CNT_W'(1);
            end
        end

        // live fault vector in flag order
        assign fault_s[c][`LFSSW_F_DOM]  =
            (dom_cnt[c] == `LFSSW_DOM_CNT_W'(DOM_CYCLES));                  // RL1
        assign fault_s[c][`LFSSW_F_TERM] = pin_s[c].term_short;
        assign fault_s[c][`LFSSW_F_OVT]  = pin_s[c].overtemp;
        assign fault_s[c][`LFSSW_F_RXL]  = pin_s[c].rxd_low;
        assign fault_s[c][`LFSSW_F_RXH]  = pin_s[c].rxd_high;
        assign fault_s[c][`LFSSW_F_TXL]  = pin_s[c].txd_low;

        // a flag holds while its fault stands; a read clears only a recovered one
        always_ff @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                latched[c] <= '0;
            end else begin
                latched[c] <= fault_s[c]
                    | (latched[c] & ~{`LFSSW_NUM_FAULTS{rd_pulse[c]}}); // RL1 RL6 RL7 RL8 RL9 RL10
            end
        end

        // wake edge latches; a read in the same cycle loses to it
        always_ff @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                wake_d[c]    <= 1'b0;
                wake_flag[c] <= 1'b0;
            end else begin
                wake_d[c]    <= pin_s[c].wake_det;
                wake_flag[c] <= wake_evt[c] | (wake_flag[c] & ~rd_pulse[c]);  // RL5
            end
        end
        assign wake_evt[c] = pin_s[c].wake_det & ~wake_d[c];

        // flag view; mode bits are live and untouched by reads
        assign lin_flags[c].dom_clamp  = latched[c][`LFSSW_F_DOM];
        assign lin_flags[c].trx_state  = pin_s[c].trx_mode;                 // RL2 RL3
        assign lin_flags[c].wake_rx    = pin_s[c].wake_rx_en;               // RL4
        assign lin_flags[c].wake_src   = wake_flag[c];
        assign lin_flags[c].term_short = latched[c][`LFSSW_F_TERM];
        assign lin_flags[c].overtemp   = latched[c][`LFSSW_F_OVT];
        assign lin_flags[c].rxd_low    = latched[c][`LFSSW_F_RXL];
        assign lin_flags[c].rxd_high   = latched[c][`LFSSW_F_RXH];
        assign lin_flags[c].txd_low    = latched[c][`LFSSW_F_TXL];
    end

    // ==========================================================
    // status word
    logic [15:0] next_status;    // status from present flags
    logic [1:0]  ch_pend;        // any pending flag per channel

    assign ch_pend[0] = (|latched[0]) | wake_flag[0];
    assign ch_pend[1] = (|latched[1]) | wake_flag[1];

    // summaries follow the flags, so they clear with them
    always_comb begin
        next_status                   = `LFSSW_STATUS_RESET;                // RL22
        next_status[`LFSSW_ST_INT]    = (|latched[0]) | (|latched[1])
                                        | ext_src.int_pend;                 // RL14
        next_status[`LFSSW_ST_WAKE]   = (|wake_flag) | ext_src.wake_pend;   // RL15
        next_status[`LFSSW_ST_RST]    = ext_src.rst_pend;                   // RL16
        next_status[`LFSSW_ST_CAN_G]  = ext_src.can_bus | ext_src.can_local; // RL18
        next_status[`LFSSW_ST_LIN_G]  = |ch_pend;                           // RL17
        next_status[`LFSSW_ST_IO_G]   = ext_src.io_hi | ext_src.io_lo;      // RL17
        next_status[`LFSSW_ST_SAFE_G] = ext_src.safe;                       // RL17
        next_status[`LFSSW_ST_REG_G]  = ext_src.reg_hi | ext_src.reg_lo;    // RL17
        next_status[`LFSSW_ST_CAN_BUS] = ext_src.can_bus;                   // RL18
        next_status[`LFSSW_ST_CAN_LOCAL] = ext_src.can_local;               // RL18
        next_status[`LFSSW_ST_SER2]   = ch_pend[1];                         // RL19
        next_status[`LFSSW_ST_SER1]   = ch_pend[0];                         // RL19
        next_status[`LFSSW_ST_IO_HI]  = ext_src.io_hi;                      // RL20
        next_status[`LFSSW_ST_IO_LO]  = ext_src.io_lo;                      // RL20
        next_status[`LFSSW_ST_REG_HI] = ext_src.reg_hi;                     // RL21
        next_status[`LFSSW_ST_REG_LO] = ext_src.reg_lo;                     // RL21
    end

    // live word for the system
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status_word <= `LFSSW_STATUS_RESET;
        end else begin
            status_word <= next_status;
        end
    end

    // frozen copy the link reads; it moves only while the synchronised select cs_s is high
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status_hold <= `LFSSW_STATUS_RESET;
        end else if (cs_s) begin
            status_hold <= next_status;
        end
    end

    // ==========================================================
    // checks in the clk domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    a_dom_clamp_time: assert property (                                     // RL1
        $rose(latched[1][`LFSSW_F_DOM])
            |-> $past(dom_cnt[1]) == `LFSSW_DOM_CNT_W'(DOM_CYCLES)
    ) else $error("clamp flag set at wrong dominant time");

    a_trx_read_keep: assert property (                                      // RL2
        rd_pulse[1] && pin_s[1].trx_mode ##1 pin_s[1].trx_mode |-> lin_flags[1].trx_state
    ) else $error("flag read cleared transceiver state");

    a_trx_mode_fall: assert property (                                      // RL3
        $fell(pin_s[1].trx_mode) |-> !lin_flags[1].trx_state
    ) else $error("transceiver state did not fall");

    a_wake_rx_keep: assert property (                                       // RL4
        rd_pulse[1] && pin_s[1].wake_rx_en ##1 pin_s[1].wake_rx_en |-> lin_flags[1].wake_rx
    ) else $error("flag read cleared wake receiver bit");

    a_wake_src_read: assert property (                                      // RL5
        rd_pulse[0] && !wake_evt[0] |=> !lin_flags[0].wake_src
    ) else $error("wake source not cleared by read");

    // a wake edge must always leave its flag set
    a_wake_set_wins: assert property (                                      // RL5
        wake_evt[0] |=> lin_flags[0].wake_src
    ) else $error("wake event lost");

    a_term_needs_read: assert property (                                    // RL6
        $fell(lin_flags[0].term_short) |-> $past(rd_pulse[0])
            && !$past(pin_s[0].term_short)
    ) else $error("termination flag cleared without read");

    a_ovt_set_wins: assert property (                                       // RL7
        pin_s[1].overtemp && rd_pulse[1] |=> lin_flags[1].overtemp
    ) else $error("overtemperature flag lost to read");

    a_rxd_low_hold: assert property (                                       // RL8
        pin_s[0].rxd_low && !rd_pulse[0] ##1 !pin_s[0].rxd_low && !rd_pulse[0]
            |=> lin_flags[0].rxd_low
    ) else $error("receive low flag not held");

    // a recovered fault still needs its read before it clears
    a_rxd_high_read: assert property (                                      // RL9
        $fell(lin_flags[1].rxd_high) |-> $past(rd_pulse[1])
            && !$past(pin_s[1].rxd_high)
    ) else $error("receive recessive flag cleared without read");

    a_txd_low_set: assert property (                                        // RL10
        pin_s[1].txd_low |=> lin_flags[1].txd_low ##1 status_word[`LFSSW_ST_INT]
    ) else $error("transmit low flag or summary missing");

    a_int_summary: assert property (                                        // RL14
        ##1 status_word[`LFSSW_ST_INT]
            == ($past(|latched[0] | |latched[1]) | $past(ext_src.int_pend))
    ) else $error("interrupt summary wrong");

    a_lin_group: assert property (                                          // RL19
        status_word[`LFSSW_ST_LIN_G]
            == (status_word[`LFSSW_ST_SER1] | status_word[`LFSSW_ST_SER2])
    ) else $error("serial bus group bit wrong");

    a_can_group: assert property (                                          // RL18
        status_word[`LFSSW_ST_CAN_BUS] |-> status_word[`LFSSW_ST_CAN_G]
    ) else $error("fieldbus group bit missing");

    // main scenarios reached
    c_clamp_seen: cover property (latched[1][`LFSSW_F_DOM]);
    c_read_clear: cover property (
        lin_flags[1].rxd_high ##1 rd_pulse[1] ##1 !lin_flags[1].rxd_high
    );
    c_wake_both: cover property (wake_flag[0] && wake_flag[1]);
    c_live_off: cover property ($fell(lin_flags[1].trx_state));

    // ==========================================================
    // checks in the link domain
    a_read_fixed_only: assert property (                                    // RL13
        @(posedge spi_sclk) disable iff (spi_cs_n)
        bit_cnt >= `LFSSW_FIXED_BITS && cmd_type != `LFSSW_CMD_WRITE
            |-> spi_miso_out == 1'b0
    ) else $error("read frame returned extended byte");

    a_write_ext_byte: assert property (                                     // RL12
        @(posedge spi_sclk) disable iff (spi_cs_n)
        bit_cnt == 5'h08 && cmd_type == `LFSSW_CMD_WRITE
            |-> spi_miso_out == status_hold[7]
    ) else $error("write frame extended byte missing");

    c_write_frame: cover property (
        @(posedge spi_sclk) bit_cnt == 5'h0F && cmd_type == `LFSSW_CMD_WRITE
    );

endmodule

// File: verif/lfssw_spi_host.sv
`timescale 1ns/10ps
// ==========================================================
// spi master standing in for the host controller, mode 0
module lfssw_spi_host #(
    parameter real HALF_NS = 80.0       // half of the 160 ns link period
) (
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso_out,
    input  wire logic spi_miso_oe_n
);
    // idle: clock parked low between frames, nothing selected
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // one 16 bit frame, msb first; miso taken just before each rising edge
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rx);
        #3.7;
        spi_cs_n = 1'b0;
        for (int k = 15; k >= 0; k--) begin
            spi_mosi = cmd[k];
            #(HALF_NS);
            // an undriven miso must never read as a valid bit
            rx[k] = (spi_miso_oe_n === 1'b0) ? spi_miso_out : 1'bx;
            spi_sclk = 1'b1;
            #(HALF_NS);
            spi_sclk = 1'b0;
        end
        #(HALF_NS);
        spi_cs_n = 1'b1;
        // a released line does not keep its last value
        spi_mosi = ~spi_mosi;
        #(HALF_NS);
    endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import lfssw_pkg::*;
    // ==========================================================
    // signals
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    lfssw_lin_in_t    [1:0] lin_in = '0;
    lfssw_ext_src_t         ext_src = '0;
    lfssw_lin_flags_t [1:0] lin_flags;
    logic [15:0]            status_word;
    logic                   spi_sclk;
    logic                   spi_cs_n;
    logic                   spi_mosi;
    logic                   spi_miso_out;
    logic                   spi_miso_oe_n;
    logic [15:0]            rx;
    int                     n_errors = 0;
    int                     samples_checked = 0;

    // ==========================================================
    // design with a shortened dominant timeout, and the host
    lfssw_status #(.DOM_CYCLES(20)) dut_u (
        .clk(clk), .rst_n(rst_n), .lin_in(lin_in), .ext_src(ext_src),
        .lin_flags(lin_flags), .status_word(status_word), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out),
        .spi_miso_oe_n(spi_miso_oe_n));
    lfssw_spi_host host_u (
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n));

    // 100 MHz system clock
    always #5 clk = ~clk;

    // ==========================================================
    // helpers
    // wait n edges, then step off the edge
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // flag read frame of one channel, then let the clear land
    task automatic rd_flags(int ch);
        host_u.xfer(ch ? 16'h2980 : 16'h2780, rx);
        tick(8);
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // every outside source alone: status word, write frame, read frame
    task automatic t_ext();
        logic [15:0] exp [10] = '{16'h8000, 16'h4000, 16'h2000, 16'h1080, 16'h1040,
                                  16'h0408, 16'h0404, 16'h0200, 16'h0102, 16'h0101};
        logic [1:0]  rd [3] = '{2'h0, 2'h2, 2'h3};
        for (int i = 0; i < 10; i++) begin
            ext_src = lfssw_ext_src_t'(10'h200 >> i);
            tick(4);
            chk("status_word", exp[i], status_word);
            host_u.xfer(16'h4000, rx);
            chk("miso write", exp[i], rx);
            host_u.xfer({rd[i % 3], 14'h0000}, rx);
            chk("miso read", {exp[i][15:8], 8'h00}, rx);
            tick(1);
        end
        ext_src = '0;
        tick(4);
        chk("status idle", 16'h0000, status_word);
    endtask

    // each latched fault but the dominant clamp: kept while present, kept until read, then cleared
    task automatic t_fault();
        for (int ch = 0; ch < 2; ch++) begin
            for (int f = 0; f < 5; f++) begin
                // input bits 7..3 map to flag bits 4..0
                lin_in[ch][7-f] = 1'b1;
                tick(6);
                chk("flag set", 1, lin_flags[ch][4-f]);
                chk("status fault", 16'h8800 | (16'h0010 << ch), status_word);
                rd_flags(ch);
                chk("flag present", 1, lin_flags[ch][4-f]);
                lin_in[ch][7-f] = 1'b0;
                tick(6);
                chk("flag unread", 1, lin_flags[ch][4-f]);
                rd_flags(ch);
                chk("flag read", 0, lin_flags[ch][4-f]);
                chk("status clear", 16'h0000, status_word);
            end
        end
    endtask

    // dominant clamp needs the full timeout before it latches
    task automatic t_dom();
        lin_in[1].bus_dominant = 1'b1;
        tick(22);
        chk("clamp early", 0, lin_flags[1].dom_clamp);
        tick(1);
        chk("clamp set", 1, lin_flags[1].dom_clamp);
        lin_in[1].bus_dominant = 1'b0;
        tick(4);
        chk("clamp unread", 1, lin_flags[1].dom_clamp);
        rd_flags(1);
        chk("clamp read", 0, lin_flags[1].dom_clamp);
    endtask

    // wake event latches the source, a read clears it
    task automatic t_wake();
        lin_in[0].wake_det = 1'b1;
        tick(4);
        lin_in[0].wake_det = 1'b0;
        tick(4);
        chk("wake src", 1, lin_flags[0].wake_src);
        chk("status wake", 16'h4810, status_word);
        rd_flags(0);
        chk("wake src read", 0, lin_flags[0].wake_src);
    endtask

    // live bits follow the mode and survive a flag read
    task automatic t_live();
        lin_in[1].trx_mode = 1'b1;
        lin_in[1].wake_rx_en = 1'b1;
        tick(4);
        rd_flags(1);
        chk("trx state", 1, lin_flags[1].trx_state);
        chk("wake rx", 1, lin_flags[1].wake_rx);
        lin_in[1].trx_mode = 1'b0;
        lin_in[1].wake_rx_en = 1'b0;
        tick(4);
        chk("trx state off", 0, lin_flags[1].trx_state);
        chk("wake rx off", 0, lin_flags[1].wake_rx);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(4);
        chk("reset status", 16'h0000, status_word);
        t_ext();
        t_fault();
        t_dom();
        t_wake();
        t_live();
        print_verdict();
    end

    // cuts a hang short well beyond the expected run time
    initial begin
        #600000;
        n_errors++;
        print_verdict();
    end
endmodule
